// file: src/sld_map.vh
`ifndef SLD_MAP_VH
`define SLD_MAP_VH
// stage count of shift register, latch bank and outputs
`define SLD_WIDTH      8
`define SLD_MSB        7
// reset values
`define SLD_ZERO8      8'h00
`define SLD_ONES8      8'hff
`define SLD_ZERO1      1'b0
`define SLD_ONE1       1'b1
`define SLD_ZERO2      2'h0
`define SLD_ONES2      2'h3
// buffer depth counter
`define SLD_CNT_ZERO   2'h0
`define SLD_CNT_ONE    2'h1
`define SLD_CNT_FULL   2'h2
// reference clock period and minimum strobe wait after a shift, in ns
`define SLD_CLK_NS     25
`define SLD_STB_GAP_NS 30
`endif

// file: src/sld_buf2.v
`timescale 1ns/1ps
`include "sld_map.vh"
// two-entry buffer carrying shift events to the register bank
module sld_buf2 (
  clk,
  rst_n,
  in_valid,
  in_ready,
  in_data,
  out_valid,
  out_ready,
  out_data
);
  input  wire       clk;
  input  wire       rst_n;
  input  wire       in_valid;
  output wire       in_ready;
  input  wire       in_data;
  output wire       out_valid;
  input  wire       out_ready;
  output wire       out_data;

  reg  [1:0] cnt_r;
  reg        slot0_r;
  reg        slot1_r;
  wire       push;
  wire       pop;

  assign push      = in_valid && (cnt_r != `SLD_CNT_FULL);
  assign pop       = out_valid && out_ready;
  assign in_ready  = (cnt_r != `SLD_CNT_FULL);
  assign out_valid = (cnt_r != `SLD_CNT_ZERO);
  assign out_data  = slot0_r;

  // slot0 is the head; slot1 only used when two words wait
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_r   <= `SLD_CNT_ZERO;
      slot0_r <= `SLD_ZERO1;
      slot1_r <= `SLD_ZERO1;
    end else begin
      case ({push, pop})
        2'b10: begin
          if (cnt_r == `SLD_CNT_ZERO) begin
            slot0_r <= in_data;
          end else begin
            slot1_r <= in_data;
          end
          cnt_r <= cnt_r + `SLD_CNT_ONE;
        end
        2'b01: begin
          slot0_r <= slot1_r;
          cnt_r   <= cnt_r - `SLD_CNT_ONE;
        end
        2'b11: begin
          if (cnt_r == `SLD_CNT_ONE) begin
            slot0_r <= in_data;
          end else begin
            slot0_r <= slot1_r;
            slot1_r <= in_data;
          end
        end
        default: begin
          cnt_r <= cnt_r;
        end
      endcase
    end
  end
endmodule // sld_buf2

// file: src/sld_driver.v
// Notes on behaviour
// - rising shift clock captures serial input
// - each rising edge shifts toward serial output
// - strobe high copies stages into latches
// - latches follow while strobe high, else hold
// - disable high turns all driver outputs off; ser_out keeps shifting
// - disable low: outputs show latch contents
`timescale 1ns/1ps
`include "sld_map.vh"
module sld_driver (
  ref_clk,
  rst_n,
  ser_in,
  shift_clk,
  strobe,
  out_disable,
  ser_out,
  drv_on,
  shift_stall
);
  input  wire                   ref_clk;
  input  wire                   rst_n;
  input  wire                   ser_in;
  input  wire                   shift_clk;
  input  wire                   strobe;
  input  wire                   out_disable;
  output reg                    ser_out;
  output reg  [`SLD_MSB:0]      drv_on;
  output reg                    shift_stall;

  // synchroniser stages, one pair per pin
  reg  [1:0]          sin_s_r;
  reg  [1:0]          sck_s_r;
  reg  [1:0]          stb_s_r;
  reg  [1:0]          dis_s_r;
  // last synchronised shift clock level, for edge finding
  reg                 sck_d_r;
  // storage: stage n feeds latch n feeds output n
  reg  [`SLD_MSB:0]   shreg_r;
  reg  [`SLD_MSB:0]   shreg_nxt;
  reg  [`SLD_MSB:0]   latch_r;
  reg  [`SLD_MSB:0]   latch_nxt;
  // next values of the registered outputs
  reg  [`SLD_MSB:0]   drv_nxt;
  reg                 ser_nxt;
  reg                 stall_nxt;
  // clean pin levels after the second flop
  wire                sin_lvl;
  wire                sck_lvl;
  wire                stb_lvl;
  wire                dis_lvl;
  // edge queue handshake
  wire                sck_rise;
  wire                buf_in_ready;
  wire                buf_valid;
  wire                buf_data;
  wire                shift_take;

  // one synchroniser step; the pin only ever enters the first flop
  function [1:0] sync_step;
    input [1:0] stages;
    input       pin;
    begin
      sync_step = {stages[0], pin};
    end
  endfunction

  // one place toward the serial output, new bit into stage 0
  function [`SLD_MSB:0] shift_in;
    input [`SLD_MSB:0] stages;
    input              bit_in;
    begin
      shift_in = {stages[`SLD_MSB-1:0], bit_in};
    end
  endfunction

  // blanking acts on the drivers only, never on what is stored
  function [`SLD_MSB:0] gate_drive;
    input              off;
    input [`SLD_MSB:0] held;
    begin
      if (off) begin
        gate_drive = `SLD_ZERO8;
      end else begin
        gate_drive = held;
      end
    end
  endfunction

  // serial data pin; same depth as the clock path keeps bit and edge paired
  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      sin_s_r <= `SLD_ZERO2;
    end else begin
      sin_s_r <= sync_step(sin_s_r, ser_in);
    end
  end

  // shift clock pin
  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      sck_s_r <= `SLD_ZERO2;
    end else begin
      sck_s_r <= sync_step(sck_s_r, shift_clk);
    end
  end

  // strobe pin
  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      stb_s_r <= `SLD_ZERO2;
    end else begin
      stb_s_r <= sync_step(stb_s_r, strobe);
    end
  end

  // disable pin resets high so drivers stay off until the pin is seen
  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      dis_s_r <= `SLD_ONES2;
    end else begin
      dis_s_r <= sync_step(dis_s_r, out_disable);
    end
  end

  // previous clock level, reset low to match the idle pin
  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      sck_d_r <= `SLD_ZERO1;
    end else begin
      sck_d_r <= sck_lvl;
    end
  end

  // only the second flop of each pair is read past this point
  assign sin_lvl = sin_s_r[1];
  assign sck_lvl = sck_s_r[1];
  assign stb_lvl = stb_s_r[1];
  assign dis_lvl = dis_s_r[1];

  // data is taken with the clock edge; setup is the controller's job
  assign sck_rise = sck_lvl && !sck_d_r;

  // edges queue here; the bank drains one per cycle, so it never fills
  sld_buf2 u_buf (
    .clk       (ref_clk),
    .rst_n     (rst_n),
    .in_valid  (sck_rise),
    .in_ready  (buf_in_ready),
    .in_data   (sin_lvl),
    .out_valid (buf_valid),
    .out_ready (`SLD_ONE1),
    .out_data  (buf_data)
  );

  // the bank is always ready, so every valid word is a pop
  assign shift_take = buf_valid;

  // next shift register value, stage n into stage n+1
  always @* begin
    shreg_nxt = shreg_r;
    if (shift_take) begin
      shreg_nxt = shift_in(shreg_r, buf_data);
    end
  end

  // shift register storage; only reset and queued edges move it
  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      shreg_r <= `SLD_ZERO8;
    end else begin
      shreg_r <= shreg_nxt;
    end
  end

  // transparent while strobe high, hold when low
  always @* begin
    latch_nxt = latch_r;
    if (stb_lvl) begin
      latch_nxt = shreg_r;
    end
  end

  // latch bank; follows the register one cycle late while open
  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      latch_r <= `SLD_ZERO8;
    end else begin
      latch_r <= latch_nxt;
    end
  end

  // output next values; disable gates drivers only
  always @* begin
    drv_nxt   = gate_drive(dis_lvl, latch_r);
    ser_nxt   = shreg_r[`SLD_MSB];
    stall_nxt = !buf_in_ready;
  end

  // driver outputs registered so no pin sees a decode glitch
  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      drv_on <= `SLD_ZERO8;
    end else begin
      drv_on <= drv_nxt;
    end
  end

  // cascade output; a following device sees the last stage
  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      ser_out <= `SLD_ZERO1;
    end else begin
      ser_out <= ser_nxt;
    end
  end

  // full queue flag; stays low while the bank drains every cycle
  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      shift_stall <= `SLD_ZERO1;
    end else begin
      shift_stall <= stall_nxt;
    end
  end
endmodule // sld_driver

// file: tb/sld_driver_assertions.sv
`timescale 1ns/1ps
module sld_driver_assertions (
  input wire       ref_clk,
  input wire       rst_n,
  input wire       ser_in,
  input wire       shift_clk,
  input wire       strobe,
  input wire       out_disable,
  input wire       ser_out,
  input wire [7:0] drv_on,
  input wire       shift_stall
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  // six cycles flush the pin synchronisers
  sequence s_live;
    (strobe && !out_disable)[*6];
  endsequence
  sequence s_shut;
    (!strobe && !out_disable)[*6];
  endsequence
  chk_dis_off: assert property (out_disable[*4] |=> drv_on == 8'h00)
    else $error("drivers on while disabled");
  chk_rst_off: assert property ($rose(rst_n) |-> drv_on == 8'h00 ##1 drv_on == 8'h00)
    else $error("drivers on after reset");
  chk_latch_hold: assert property (s_shut |-> $stable(drv_on))
    else $error("latch moved with strobe low");
  chk_show_latch: assert property (s_shut |-> drv_on == $past(drv_on, 2))
    else $error("outputs left the latch");
  chk_latch_copy: assert property (s_live |-> drv_on[7] == $past(ser_out))
    else $error("latch missed last stage");
  chk_ser_idle: assert property ($stable(shift_clk)[*6] |-> $stable(ser_out))
    else $error("shift without clock edge");
  chk_ser_cap: assert property ($changed(ser_out) |->
    $past(shift_clk, 2) || $past(shift_clk, 3) || $past(shift_clk, 4))
    else $error("shift away from clock rise");
  chk_no_stall: assert property (!shift_stall)
    else $error("buffer stalled");
endmodule // sld_driver_assertions
bind sld_driver sld_driver_assertions u_chk (.ref_clk, .rst_n, .ser_in, .shift_clk,
  .strobe, .out_disable, .ser_out, .drv_on, .shift_stall);

// file: tb/sld_ctl_model.sv
`timescale 1ns/1ps
// controller side: data a phase ahead of each clock rise
module sld_ctl_model (
  input  wire ref_clk,
  output reg  ser_in,
  output reg  shift_clk
);
  initial begin
    ser_in = 1'b0;
    shift_clk = 1'b0;
  end
  // after hold runs out the line shows the inverse, not the old bit
  task put_bit(input b);
    begin
      ser_in = b;
      repeat (4) @(posedge ref_clk) #1;
      shift_clk = 1'b1;
      repeat (4) @(posedge ref_clk) #1;
      shift_clk = 1'b0;
      ser_in = ~b;
      // an edge passes so the next bit never lands in the same step
      @(posedge ref_clk) #1;
    end
  endtask
  // msb first so bit n ends in stage n
  task put_byte(input [7:0] v);
    integer i;
    begin
      for (i = 7; i >= 0; i = i - 1) put_bit(v[i]);
    end
  endtask
endmodule // sld_ctl_model

// file: tb/tb.sv
`timescale 1ns/1ps
module tb;
  reg        ref_clk = 1'b0;
  reg        rst_n = 1'b0;
  reg        strobe = 1'b0;
  reg        out_disable = 1'b0;
  wire       ser_in;
  wire       shift_clk;
  wire       ser_out;
  wire [7:0] drv_on;
  wire       shift_stall;
  integer    num_errors = 0;
  integer    tests_run = 0;
  always #12.5 ref_clk = ~ref_clk;
  sld_ctl_model ctl (.ref_clk, .ser_in, .shift_clk);
  sld_driver uut (.ref_clk, .rst_n, .ser_in, .shift_clk, .strobe, .out_disable,
    .ser_out, .drv_on, .shift_stall);
  task check(input [47:0] name, input [7:0] exp, input [7:0] got);
    begin
      tests_run = tests_run + 1;
      if (got !== exp) begin
        num_errors = num_errors + 1;
        $display("BAD %0s exp %h got %h", name, exp, got);
      end
    end
  endtask
  // latency is fixed, so a fixed wait covers the pipeline
  task settle;
    repeat (8) @(posedge ref_clk) #1;
  endtask
  task t_load;
    begin
      ctl.put_byte(8'ha5);
      settle;
      check("hold", 8'h00, drv_on);
      check("sout", 8'h01, {7'h00, ser_out});
      strobe = 1'b1;
      settle;
      check("load", 8'ha5, drv_on);
    end
  endtask
  // shifting while blanked with strobe low must not touch the latches
  task t_dis;
    begin
      out_disable = 1'b1;
      settle;
      check("off", 8'h00, drv_on);
      strobe = 1'b0;
      ctl.put_byte(8'h3c);
      out_disable = 1'b0;
      settle;
      check("kept", 8'ha5, drv_on);
      strobe = 1'b1;
      settle;
      check("new", 8'h3c, drv_on);
      ctl.put_bit(1'b1);
      settle;
      check("follow", 8'h79, drv_on);
    end
  endtask
  // latches bypassed: strobe stays high, so entry happens blanked
  task t_bypass;
    begin
      out_disable = 1'b1;
      ctl.put_byte(8'hc3);
      check("blank", 8'h00, drv_on);
      out_disable = 1'b0;
      settle;
      check("bypass", 8'hc3, drv_on);
      check("stall", 8'h00, {7'h00, shift_stall});
    end
  endtask
  task wrap_up;
    begin
      $display("checks %0d errors %0d", tests_run, num_errors);
      if (num_errors == 0 && tests_run > 0)
        $display("TEST PASSED");
      else
        $display("TEST FAILED");
      $finish;
    end
  endtask
  initial begin
    repeat (16) @(posedge ref_clk) #1;
    rst_n = 1'b1;
    settle;
    check("reset", 8'h00, drv_on);
    t_load;
    t_dis;
    t_bypass;
    wrap_up;
  end
endmodule // tb
